// file: hw/tsc_consts.vh
/*
 constants for the test start controller: glitch filter, test timing, modes, alarm modes.
 assumes one 100 MHz clock and a synchronous active-high reset.
*/
// What this block does
// - rising start input begins a new test or restarts the running one.
// - at test end, start still asserted launches another test once the result arrives.
// - start dropping aborts running test; last completed result stays shown.
// - start, repeat and abort act whether or not continuous testing is on.
// - continuous plus stop-when-clean with start held: stop on drop or clean.
// - delimited option lets start level set each single test's duration.
// - accept starts from keypad button, serial command and periodic schedule.
// - start input interpretation follows the configured test mode.
// - one switched input and two switched outputs for command and control.
// - data pair selectable as RS485, CAN or current-loop output.
// - RS485 control uses Modbus RTU with an external master.
// - two switched outputs follow the configured alarm mode.
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH
`define TSC_CLK_MHZ 100
`define TSC_FILT_US 1000
// counts written out at counter width: the 120 s product overflows 32-bit arithmetic
`define TSC_FILT_CYC 17'h1_86a0
`define TSC_FILT_W 17
`define TSC_TEST_S 120
`define TSC_TEST_CYC 40'h02_cb41_7800
`define TSC_TIME_W 40
// test mode field
`define TSC_TMODE_W 2
`define TSC_TMODE_OFF 2'h0
`define TSC_TMODE_INPUT 2'h1
`define TSC_TMODE_PERIODIC 2'h2
`define TSC_TMODE_BOTH 2'h3
// alarm mode field
`define TSC_AMODE_W 2
`define TSC_AMODE_RESULT 2'h0
`define TSC_AMODE_BUSY 2'h1
`define TSC_AMODE_CLEAN 2'h2
`define TSC_AMODE_OFF 2'h3
// data pair mode field
`define TSC_PAIR_W 2
`define TSC_PAIR_RS485 2'h0
`define TSC_PAIR_CAN 2'h1
`define TSC_PAIR_LOOP 2'h2
`endif

// file: hw/tsc_filter.v
/*
 two-flop synchroniser and glitch filter with edge pulses for the start input.
 assumes input asynchronous to SYS_CLK_I is tolerable through two flops.
*/
`timescale 1ns/10ps
`include "tsc_consts.vh"
module tsc_filter #(
    parameter [`TSC_FILT_W-1:0] FILT_CYC = `TSC_FILT_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire raw_i,
    output reg level_o,
    output reg rise_o,
    output reg fall_o
);
    reg meta_ff;
    reg sync_ff;
    reg [`TSC_FILT_W-1:0] cnt_ff;
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            cnt_ff <= {`TSC_FILT_W{1'b0}};
            level_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            meta_ff <= raw_i;
            sync_ff <= meta_ff;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (sync_ff == level_o) begin
                cnt_ff <= {`TSC_FILT_W{1'b0}};
            end else if (cnt_ff >= FILT_CYC - 1'b1) begin
                // level accepted only after holding for the filter time
                cnt_ff <= {`TSC_FILT_W{1'b0}};
                level_o <= sync_ff;
                rise_o <= sync_ff;
                fall_o <= ~sync_ff;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end
endmodule // tsc_filter

// file: hw/tsc_timer.v
/*
 loadable down-counter giving a done pulse when a test or interval elapses.
 assumes caller reloads by start pulse; stop halts it but keeps the count.
*/
`timescale 1ns/10ps
`include "tsc_consts.vh"
module tsc_timer (
    input wire clk_i,
    input wire rst_i,
    input wire load_i,
    input wire stop_i,
    input wire [`TSC_TIME_W-1:0] len_i,
    output reg run_o,
    output reg done_o
);
    reg [`TSC_TIME_W-1:0] cnt_ff;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= {`TSC_TIME_W{1'b0}};
            run_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (load_i) begin
                cnt_ff <= len_i;
                run_o <= 1'b1;
            end else if (stop_i) begin
                run_o <= 1'b0;
            end else if (run_o) begin
                if (cnt_ff <= 1) begin
                    run_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
            end
        end
    end
endmodule // tsc_timer

// file: hw/tsc_top.v
/*
 test start controller: sequences tests from the start input, button, serial command
 and periodic schedule; drives the two switched outputs and the data pair mode selects.
 assumes the measurement engine reports a result pulse with a clean flag, and that the
 serial command request is decoded from Modbus RTU frames upstream.
*/
`timescale 1ns/10ps
`include "tsc_consts.vh"
module tsc_top #(
    parameter [`TSC_FILT_W-1:0] FILT_CYC = `TSC_FILT_CYC,
    parameter [`TSC_TIME_W-1:0] TEST_CYC = `TSC_TEST_CYC
) (
    // clock and reset
    input wire SYS_CLK_I,
    input wire RST_I,
    // switched start input
    input wire START_IN_I,
    // other start and stop sources
    input wire BUTTON_I,
    input wire KEYPAD_FITTED_I,
    input wire SERIAL_START_I,
    input wire SERIAL_STOP_I,
    // configuration
    input wire [`TSC_TMODE_W-1:0] TEST_MODE_I,
    input wire CONTINUOUS_I,
    input wire STOP_CLEAN_I,
    input wire DELIMITED_I,
    input wire [`TSC_TIME_W-1:0] PERIOD_I,
    input wire [`TSC_AMODE_W-1:0] ALARM_MODE_I,
    input wire [`TSC_PAIR_W-1:0] PAIR_MODE_I,
    // measurement engine
    input wire RESULT_VALID_I,
    input wire RESULT_CLEAN_I,
    input wire ALARM_I,
    // test control and status
    output wire TEST_START_O,
    output wire TEST_ABORT_O,
    output wire TEST_END_O,
    output reg TESTING_O,
    output reg LAST_CLEAN_O,
    output reg RESULT_SEEN_O,
    // switched outputs
    output reg OUT1_O,
    output reg OUT2_O,
    // data pair selects
    output reg PAIR_RS485_O,
    output reg PAIR_CAN_O,
    output reg PAIR_LOOP_O
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_TEST = 3'b010;
    localparam [2:0] ST_HOLD = 3'b100;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg start_pls;
    reg abort_pls;
    reg end_pls;
    reg alarm_ff;
    wire lvl;
    wire rise;
    wire fall;
    wire tmr_run;
    wire tmr_done;
    wire per_run;
    wire per_done;
    wire input_mode;
    wire periodic_mode;
    wire ext_start;

    function mode_has;
        input [`TSC_TMODE_W-1:0] mode;
        input [`TSC_TMODE_W-1:0] want;
        begin
            mode_has = (mode == want) || (mode == `TSC_TMODE_BOTH);
        end
    endfunction

    tsc_filter #(.FILT_CYC(FILT_CYC)) u_filt (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .raw_i(START_IN_I),
        .level_o(lvl),
        .rise_o(rise),
        .fall_o(fall)
    );

    // the test timer is not used to end delimited tests; those end on fall
    tsc_timer u_test (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .load_i(start_pls),
        .stop_i(abort_pls | end_pls),
        .len_i(TEST_CYC),
        .run_o(tmr_run),
        .done_o(tmr_done)
    );

    // periodic schedule restarts itself each interval
    tsc_timer u_period (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .load_i(periodic_mode & ~per_run),
        .stop_i(~periodic_mode),
        .len_i(PERIOD_I),
        .run_o(per_run),
        .done_o(per_done)
    );

    assign input_mode = mode_has(TEST_MODE_I, `TSC_TMODE_INPUT);
    assign periodic_mode = mode_has(TEST_MODE_I, `TSC_TMODE_PERIODIC);
    assign ext_start = (BUTTON_I & KEYPAD_FITTED_I) | SERIAL_START_I | per_done;

    always @* begin
        nxt_state = state_ff;
        start_pls = 1'b0;
        abort_pls = 1'b0;
        end_pls = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if ((input_mode & rise) | ext_start) begin
                    start_pls = 1'b1;
                    nxt_state = ST_TEST;
                end
            end
            ST_TEST: begin
                // a delimited test ends normally on the fall, so it must not abort here
                if (input_mode & fall & ~DELIMITED_I) begin
                    abort_pls = 1'b1;
                    nxt_state = ST_IDLE;
                end else if (SERIAL_STOP_I) begin
                    abort_pls = 1'b1;
                    nxt_state = ST_IDLE;
                end else if (input_mode & rise) begin
                    start_pls = 1'b1;
                end else if (~(input_mode & DELIMITED_I) & tmr_done) begin
                    end_pls = 1'b1;
                    nxt_state = ST_HOLD;
                end else if (input_mode & DELIMITED_I & ~lvl) begin
                    end_pls = 1'b1;
                    nxt_state = ST_HOLD;
                end else if (ext_start) begin
                    start_pls = 1'b1;
                end
            end
            ST_HOLD: begin
                // wait for the measurement result before deciding to repeat
                if (input_mode & fall) begin
                    nxt_state = ST_IDLE;
                end else if (input_mode & rise) begin
                    start_pls = 1'b1;
                    nxt_state = ST_TEST;
                end else if (RESULT_VALID_I) begin
                    if (CONTINUOUS_I & STOP_CLEAN_I & RESULT_CLEAN_I) begin
                        nxt_state = ST_IDLE;
                    end else if (input_mode & lvl & ~DELIMITED_I) begin
                        start_pls = 1'b1;
                        nxt_state = ST_TEST;
                    end else if (CONTINUOUS_I & ~(input_mode & DELIMITED_I)) begin
                        start_pls = 1'b1;
                        nxt_state = ST_TEST;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end else if (ext_start) begin
                    start_pls = 1'b1;
                    nxt_state = ST_TEST;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    assign TEST_START_O = start_pls;
    assign TEST_ABORT_O = abort_pls;
    assign TEST_END_O = end_pls;

    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_ff <= ST_IDLE;
            TESTING_O <= 1'b0;
            LAST_CLEAN_O <= 1'b0;
            RESULT_SEEN_O <= 1'b0;
            alarm_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            TESTING_O <= (nxt_state != ST_IDLE);
            // only completed tests update the kept result
            if (RESULT_VALID_I && state_ff == ST_HOLD) begin
                LAST_CLEAN_O <= RESULT_CLEAN_I;
                RESULT_SEEN_O <= 1'b1;
                alarm_ff <= ALARM_I;
            end
        end
    end

    // switched outputs
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            OUT1_O <= 1'b0;
            OUT2_O <= 1'b0;
        end else begin
            case (ALARM_MODE_I)
                `TSC_AMODE_RESULT: begin
                    OUT1_O <= alarm_ff;
                    OUT2_O <= RESULT_SEEN_O & ~alarm_ff;
                end
                `TSC_AMODE_BUSY: begin
                    OUT1_O <= TESTING_O;
                    OUT2_O <= alarm_ff;
                end
                `TSC_AMODE_CLEAN: begin
                    OUT1_O <= LAST_CLEAN_O;
                    OUT2_O <= RESULT_SEEN_O & ~LAST_CLEAN_O;
                end
                default: begin
                    OUT1_O <= 1'b0;
                    OUT2_O <= 1'b0;
                end
            endcase
        end
    end

    // data pair mode selects; serial traffic itself is outside this block
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            PAIR_RS485_O <= 1'b1;
            PAIR_CAN_O <= 1'b0;
            PAIR_LOOP_O <= 1'b0;
        end else begin
            PAIR_RS485_O <= (PAIR_MODE_I == `TSC_PAIR_RS485);
            PAIR_CAN_O <= (PAIR_MODE_I == `TSC_PAIR_CAN);
            PAIR_LOOP_O <= (PAIR_MODE_I == `TSC_PAIR_LOOP);
        end
    end
endmodule // tsc_top

// file: tb/tsc_start_drv.sv
/*
 far-side start contact: a plc output or pump contact driving the start pin.
 assumes the bench sets the wanted level and a chatter enable at clock edges.
*/
`timescale 1ns/10ps
module tsc_start_drv (
    input logic clk_i,
    input logic want_i,
    input logic chatter_i,
    output logic start_o
);
    logic tog_ff = 1'b0;
    initial start_o = 1'b0;
    // chatter flips each cycle, never steady long enough to pass the filter
    always @(posedge clk_i) begin
        tog_ff <= ~tog_ff;
        start_o <= want_i | (chatter_i & tog_ff);
    end
endmodule // tsc_start_drv

// file: tb/tsc_top_chk.sv
/*
 checker for the test start controller, bound to its top ports.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module tsc_top_chk (
    input logic SYS_CLK_I, RST_I, BUTTON_I, KEYPAD_FITTED_I, SERIAL_START_I, DELIMITED_I,
    input logic RESULT_VALID_I, TEST_START_O, TEST_ABORT_O, TEST_END_O, TESTING_O,
    input logic OUT1_O, OUT2_O, PAIR_RS485_O, PAIR_CAN_O, PAIR_LOOP_O,
    input logic [1:0] TEST_MODE_I,
    input logic [1:0] ALARM_MODE_I,
    input logic [1:0] PAIR_MODE_I
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    property p_start_run; TEST_START_O |=> TESTING_O; endproperty
    a_start_run: assert property (p_start_run) else $error("no testing after start");
    property p_abort_idle; TEST_ABORT_O && !TEST_START_O |=> !TESTING_O; endproperty
    a_abort_idle: assert property (p_abort_idle) else $error("testing after abort");
    property p_end_late; TEST_START_O && !DELIMITED_I |=> !TEST_END_O [*8]; endproperty
    a_end_late: assert property (p_end_late) else $error("test ended too early");
    property p_button; BUTTON_I && KEYPAD_FITTED_I && !TESTING_O |-> TEST_START_O; endproperty
    a_button: assert property (p_button) else $error("button start lost");
    property p_serial; SERIAL_START_I && !TESTING_O |-> TEST_START_O; endproperty
    a_serial: assert property (p_serial) else $error("serial start lost");
    property p_mode_off;
        TEST_MODE_I == 2'h0 && !BUTTON_I && !SERIAL_START_I && !RESULT_VALID_I |-> !TEST_START_O;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("start with mode off");
    property p_pair_loop; PAIR_MODE_I == 2'h2 |=> PAIR_LOOP_O && !PAIR_CAN_O && !PAIR_RS485_O; endproperty
    a_pair_loop: assert property (p_pair_loop) else $error("pair loop select wrong");
    property p_pair_none; PAIR_MODE_I == 2'h3 |=> !PAIR_LOOP_O && !PAIR_CAN_O && !PAIR_RS485_O; endproperty
    a_pair_none: assert property (p_pair_none) else $error("pair select not cleared");
    property p_out_off; ALARM_MODE_I == 2'h3 |=> !OUT1_O && !OUT2_O; endproperty
    a_out_off: assert property (p_out_off) else $error("outputs on in off mode");
    property p_out_busy; (ALARM_MODE_I == 2'h1 && TESTING_O) [*2] |-> OUT1_O; endproperty
    a_out_busy: assert property (p_out_busy) else $error("busy output low");
    c_repeat: cover property (RESULT_VALID_I && TEST_START_O);
    c_abort: cover property (TEST_ABORT_O);
    c_end: cover property (TEST_END_O);
endmodule // tsc_top_chk

// file: tb/tsc_top_tb_top.sv
/*
 self-checking bench for the test start controller with a start-contact model.
 assumes short filter and test counts set through the top parameters.
*/
`timescale 1ns/10ps
module tsc_top_tb_top;
    logic clk = 0, rst = 1, want = 0, chat = 0, btn = 0, kp = 0, sst = 0, ssp = 0;
    logic cont = 0, scl = 0, dlm = 0, rv = 0, rc = 0, alm = 0;
    logic [1:0] tm = 2'h0, am = 2'h1, pm = 2'h0;
    logic [39:0] per = 40'h00_0000_000a;
    logic [31:0] seed = 32'h0000_3ba0;
    logic [31:0] r;
    wire pin, ts, ta, te, tg, lc, rs, o1, o2, p0, p1, p2;
    int num_errors = 0, num_checks = 0, n_st = 0, n_ab = 0, n_en = 0, cyc = 0;
    always #5 clk = ~clk;
    tsc_start_drv drv_u (.clk_i(clk), .want_i(want), .chatter_i(chat), .start_o(pin));
    tsc_top #(.FILT_CYC(17'h0_0004), .TEST_CYC(40'h00_0000_0014)) dut_u (
        .SYS_CLK_I(clk), .RST_I(rst), .START_IN_I(pin), .BUTTON_I(btn), .KEYPAD_FITTED_I(kp),
        .SERIAL_START_I(sst), .SERIAL_STOP_I(ssp), .TEST_MODE_I(tm), .CONTINUOUS_I(cont),
        .STOP_CLEAN_I(scl), .DELIMITED_I(dlm), .PERIOD_I(per), .ALARM_MODE_I(am), .PAIR_MODE_I(pm),
        .RESULT_VALID_I(rv), .RESULT_CLEAN_I(rc), .ALARM_I(alm), .TEST_START_O(ts), .TEST_ABORT_O(ta),
        .TEST_END_O(te), .TESTING_O(tg), .LAST_CLEAN_O(lc), .RESULT_SEEN_O(rs), .OUT1_O(o1),
        .OUT2_O(o2), .PAIR_RS485_O(p0), .PAIR_CAN_O(p1), .PAIR_LOOP_O(p2));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(string nm, logic [7:0] s, logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task run(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic await(ref int c, input int t);
        for (int i = 0; i < 60 && c < t; i++) @(posedge clk);
    endtask
    // one-cycle pulse: 0 button, 1 serial stop, 2 serial start
    task pulse(input int w);
        @(posedge clk);
        btn <= (w == 0);
        ssp <= (w == 1);
        sst <= (w == 2);
        @(posedge clk);
        btn <= 0;
        ssp <= 0;
        sst <= 0;
    endtask
    // model of pulse counts, compared with the expected counts below;
    // counted mid-cycle so tasks resuming at the next edge already see them
    always @(negedge clk) begin
        cyc++;
        if (!rst) begin
            n_st += ts;
            n_ab += ta;
            n_en += te;
        end
        if (cyc == 4000) begin
            num_errors++;
            give_verdict;
        end
    end
    initial begin
        run(1); #1 chk("reset outs", {tg, lc, rs, o1, o2, p0, p1, p2}, 8'h04);
        run(2); rst <= 0;
        @(posedge clk) tm <= 2'h1; chat <= 1;
        run(20); chat <= 0; chk("glitch", n_st, 0);
        want <= 1; await(n_st, 1); #1 chk("testing", tg, 1);
        await(n_en, 1); rv <= 1; rc <= 0; alm <= 1;
        @(posedge clk) rv <= 0;
        @(posedge clk); #1 chk("repeat", n_st, 2);
        chk("busy outs", {o1, o2}, 3);
        $display("start and repeat done");
        @(posedge clk) want <= 0; await(n_ab, 1); #1 chk("abort", {tg, lc}, 0);
        @(posedge clk) cont <= 1; scl <= 1; want <= 1; await(n_st, 3); await(n_en, 2);
        rv <= 1; rc <= 1; alm <= 0;
        @(posedge clk) rv <= 0; rc <= 0;
        run(3); #1 chk("clean stop", n_st, 3);
        chk("clean flag", {tg, lc, rs}, 3);
        @(posedge clk) want <= 0; cont <= 0; scl <= 0; tm <= 2'h0;
        run(10); pulse(0); run(2); chk("no keypad", n_st, 3);
        @(posedge clk) kp <= 1; pulse(0); run(2); chk("button", n_st, 4);
        pulse(1); run(2); chk("serial stop", n_ab, 2);
        pulse(2); run(2); chk("serial start", n_st, 5);
        pulse(1); @(posedge clk) want <= 1; run(15); chk("mode off", n_st, 5);
        $display("sources done");
        @(posedge clk) want <= 0; run(8);
        @(posedge clk) tm <= 2'h1; dlm <= 1; want <= 1; await(n_st, 6);
        want <= 0; await(n_en, 3); run(2); chk("delimited", {n_ab[3:0], n_en[3:0]}, 8'h33);
        @(posedge clk) dlm <= 0; tm <= 2'h2; run(30); chk("periodic", n_st > 6, 1);
        $display("delimited and periodic done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) r = xs();
            pm <= r[1:0];
            am <= r[3:2];
            run(2); #1 chk("pair", {p0, p1, p2}, r[1:0] == 0 ? 4 : r[1:0] == 1 ? 2 : r[1:0] == 2 ? 1 : 0);
            // periodic tests keep running here; kept result is clean with no alarm
            chk("alarm outs", {o1, o2}, r[3:2] == 0 ? 1 : r[3:2] == 3 ? 0 : 2);
        end
        $display("pair and alarm done");
        give_verdict;
    end
endmodule // tsc_top_tb_top
bind tsc_top tsc_top_chk chk_u (.*);
